// [uio_pkg.sv]
package uio_pkg;
  // Board address pattern: 0000 010p pppx, 12 bits
  localparam int ADDR_W = 12;
  localparam logic [6:0] ADDR_FIXED_HI = 7'h02;
  localparam int ADDR_ID_LSB = 1;
  localparam int ADDR_ID_W = 4;
  localparam int ADDR_JMP_BIT = 0;
  // Write latch fields
  localparam int LATCH_W = 4;
  localparam int LATCH_LEVEL_BIT = 0;
  localparam int LATCH_CODE_LSB = 1;
  localparam int LATCH_CODE_W = 3;
  localparam logic [2:0] CODE_UNUSED = 3'h6;
  localparam logic [2:0] CODE_READ_SETUP = 3'h7;
  localparam logic [3:0] LATCH_RESET = 4'he;
  // Bus data and answers
  localparam int DATA_W = 8;
  localparam logic [7:0] PRESENCE_ANSWER = 8'hfe;
  localparam int NUM_LOADS = 6;
  localparam logic [5:0] LOADS_RESET = 6'h00;
  localparam int NUM_INPUTS = 16;
  localparam int GROUP_W = 4;
endpackage

// [uio_group_select.sv]
`timescale 1ns/1ns
// Picks every second channel of an input group, starting at the odd or even one
module uio_group_select #(
  parameter int IN_W = 8
) (
  input wire logic [IN_W-1:0] group_i,
  input wire logic odd_sel_i,
  output logic [IN_W/2-1:0] pick_o
);
  // Lowest channel lands in the lowest data bit
  always_comb begin
    for (int k = 0; k < IN_W / 2; k++) begin
      pick_o[k] = odd_sel_i ? group_i[2 * k + 1] : group_i[2 * k];
    end
  end
endmodule // uio_group_select

// [universal_io_bus_slave.sv]
// Functional notes
// - The board answers only to address 0000 010p pppx, pppp from its id setting and x set when the jumper is open.
// - A bus write fills a 4-bit latch whose D3..D1 code picks output 0 to 5, code 6 is unused, code 7 sets up a read.
// - Read setup with D0 clear selects even input channels and with D0 set selects odd ones.
// - The first group read returns the selected channels among inputs 0 to 7.
// - The second group read returns the selected channels among inputs 8 to 15.
// - Each group read gives four channels on D3..D0, lowest channel in the lowest bit.
// - A presence read to this board returns bit 0 low.
// - A broadcast reset returns the board to its reset state whether addressed or not.
// - Each input bit is 1 when its comparator sees the input above threshold and 0 otherwise.
`timescale 1ns/1ns
module universal_io_bus_slave #(
  parameter logic [3:0] BOARD_ID = 4'h0 // Set by the programmed address logic
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic address_jumper_open_i,
  input wire logic addr_strobe_i,
  input wire logic [uio_pkg::ADDR_W-1:0] bus_addr_i,
  input wire logic bus_write_cycle_i,
  input wire logic presence_read_cycle_i,
  input wire logic low_group_read_cycle_i,
  input wire logic high_group_read_cycle_i,
  input wire logic broadcast_reset_cycle_i,
  input wire logic [uio_pkg::LATCH_W-1:0] bus_data_i,
  input wire logic [uio_pkg::NUM_INPUTS-1:0] universal_inputs_i,
  output logic [uio_pkg::DATA_W-1:0] bus_data_o,
  output logic bus_data_oe_o,
  output logic [uio_pkg::NUM_LOADS-1:0] load_sink_outputs_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address match

  logic [uio_pkg::ADDR_W-1:0] own_addr;
  logic addr_hit;

  // Jumper is read live so a moved jumper takes effect on the next address cycle.
  // The id half comes from a parameter, so more than two boards on one bus need several builds
  // with different BOARD_ID values; the jumper alone only doubles that count.
  assign own_addr = {uio_pkg::ADDR_FIXED_HI, BOARD_ID, address_jumper_open_i};
  assign addr_hit = (bus_addr_i == own_addr);

  logic selected_r;
  logic selected_nxt;

  // Selection follows every address cycle; broadcast reset drops it.
  // Every board re-judges its selection on each address strobe, so at most
  // one board answers reads once the master has placed an address.
  always_comb begin
    selected_nxt = selected_r;
    if (broadcast_reset_cycle_i) begin
      selected_nxt = 1'b0;
    end else if (addr_strobe_i) begin
      selected_nxt = addr_hit;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      selected_r <= 1'b0;
    end else if (ce_i) begin
      selected_r <= selected_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode

  logic bcast_take;
  logic take_ok;
  logic wr_take;
  logic pres_take;
  logic low_take;
  logic high_take;

  // A broadcast reset reaches every board, selected or not
  assign bcast_take = broadcast_reset_cycle_i;

  // Writes and reads only count for the selected board, and a broadcast
  // reset in the same clock wins over them, so half-done work is dropped
  assign take_ok = !broadcast_reset_cycle_i && selected_r;
  assign wr_take = take_ok && bus_write_cycle_i;

  // Several read strobes in one clock resolve presence, then low, then high;
  // the master never does this, but the answer must come from one source only
  assign pres_take = take_ok && presence_read_cycle_i;
  assign low_take = take_ok && !presence_read_cycle_i && low_group_read_cycle_i;
  assign high_take = take_ok && !presence_read_cycle_i && !low_group_read_cycle_i
                     && high_group_read_cycle_i;

  ////////////////////////////////////////////////////////////////////////////
  // Write latch and load outputs

  logic [uio_pkg::LATCH_W-1:0] latch_r;
  logic [uio_pkg::LATCH_W-1:0] latch_nxt;
  // Held in pin polarity so the pins come straight from flip-flops
  logic [uio_pkg::NUM_LOADS-1:0] loads_n_r;
  logic [uio_pkg::NUM_LOADS-1:0] loads_n_nxt;
  logic [uio_pkg::LATCH_CODE_W-1:0] wr_code;
  logic wr_level;

  assign wr_code = bus_data_i[uio_pkg::LATCH_CODE_LSB +: uio_pkg::LATCH_CODE_W];
  assign wr_level = bus_data_i[uio_pkg::LATCH_LEVEL_BIT];

  // Latch is held between writes, so the read selection survives group reads.
  // Each write replaces the whole latch: an output write after a read setup
  // therefore also ends the odd selection.
  always_comb begin
    latch_nxt = latch_r;
    loads_n_nxt = loads_n_r;
    if (bcast_take) begin
      latch_nxt = uio_pkg::LATCH_RESET;
      loads_n_nxt = ~uio_pkg::LOADS_RESET;
    end else if (wr_take) begin
      latch_nxt = bus_data_i;
      // Code 6 and the read-setup code only refill the latch
      if (wr_code < uio_pkg::CODE_UNUSED) begin
        loads_n_nxt[wr_code] = ~wr_level;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_r <= uio_pkg::LATCH_RESET;
      loads_n_r <= ~uio_pkg::LOADS_RESET;
    end else if (ce_i) begin
      latch_r <= latch_nxt;
      loads_n_r <= loads_n_nxt;
    end
  end

  // Low on a pin means its driver sinks load current
  assign load_sink_outputs_n_o = loads_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read selection

  logic odd_sel;
  logic [uio_pkg::GROUP_W-1:0] low_pick;
  logic [uio_pkg::GROUP_W-1:0] high_pick;

  logic [uio_pkg::LATCH_CODE_W-1:0] held_code;
  logic held_level;

  // Split the held latch into its code and level fields
  assign held_code = latch_r[uio_pkg::LATCH_CODE_LSB +: uio_pkg::LATCH_CODE_W];
  assign held_level = latch_r[uio_pkg::LATCH_LEVEL_BIT];

  // Only a read-setup code selects odd; an output code leaves even channels.
  // Software that drives a load between setup and read must set up again.
  assign odd_sel = (held_code == uio_pkg::CODE_READ_SETUP) && held_level;

  // Both halves share one parity choice, as the master sets it once per setup

  uio_group_select #(.IN_W(2 * uio_pkg::GROUP_W)) low_sel (
    .group_i(universal_inputs_i[7:0]),
    .odd_sel_i(odd_sel),
    .pick_o(low_pick)
  );

  uio_group_select #(.IN_W(2 * uio_pkg::GROUP_W)) high_sel (
    .group_i(universal_inputs_i[15:8]),
    .odd_sel_i(odd_sel),
    .pick_o(high_pick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read answers

  logic [uio_pkg::DATA_W-1:0] rd_data_r;
  logic [uio_pkg::DATA_W-1:0] rd_data_nxt;
  logic rd_oe_r;
  logic rd_oe_nxt;

  // Answer one cycle after the read strobe; upper data lines read zero on group reads.
  // The answer is registered, which costs one cycle of latency but keeps the
  // data lines free of decode glitches while the enable is up.
  always_comb begin
    rd_data_nxt = '0;
    rd_oe_nxt = 1'b0;
    if (pres_take) begin
      rd_data_nxt = uio_pkg::PRESENCE_ANSWER;
      rd_oe_nxt = 1'b1;
    end else if (low_take) begin
      rd_data_nxt = {4'h0, low_pick};
      rd_oe_nxt = 1'b1;
    end else if (high_take) begin
      rd_data_nxt = {4'h0, high_pick};
      rd_oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_r <= '0;
      rd_oe_r <= 1'b0;
    end else if (ce_i) begin
      rd_data_r <= rd_data_nxt;
      rd_oe_r <= rd_oe_nxt;
    end
  end

  // Both come straight from flip-flops; the enable is high for one cycle
  // per answered read, so the master samples the data in that cycle only
  assign bus_data_o = rd_data_r;
  assign bus_data_oe_o = rd_oe_r;

endmodule // universal_io_bus_slave

// [uio_bus_slave_properties.sv]
`timescale 1ns/1ns
module uio_bus_slave_properties #(parameter logic [3:0] BOARD_ID = 4'h0) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic address_jumper_open_i,
  input wire logic addr_strobe_i,
  input wire logic [11:0] bus_addr_i,
  input wire logic bus_write_cycle_i,
  input wire logic presence_read_cycle_i,
  input wire logic low_group_read_cycle_i,
  input wire logic high_group_read_cycle_i,
  input wire logic broadcast_reset_cycle_i,
  input wire logic [3:0] bus_data_i,
  input wire logic [15:0] universal_inputs_i,
  input wire logic [7:0] bus_data_o,
  input wire logic bus_data_oe_o,
  input wire logic [5:0] load_sink_outputs_n_o
);
  logic sel_r;
  logic odd_r;
  wire logic brst = ce_i && broadcast_reset_cycle_i;
  wire logic go = ce_i && sel_r && !broadcast_reset_cycle_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow selection and parity; only a write of 0xf leaves the even half
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_r <= 1'b0;
      odd_r <= 1'b0;
    end else if (brst) begin
      sel_r <= 1'b0;
      odd_r <= 1'b0;
    end else if (ce_i) begin
      if (addr_strobe_i) sel_r <= bus_addr_i == {7'h02, BOARD_ID, address_jumper_open_i};
      if (bus_write_cycle_i && sel_r) odd_r <= bus_data_i == 4'hf;
    end
  end
  function automatic logic [3:0] pick(input logic [7:0] g, input logic o);
    return o ? {g[7], g[5], g[3], g[1]} : {g[6], g[4], g[2], g[0]};
  endfunction
  sequence s_read(r);
    go && r;
  endsequence
  //////////////////////////////////////////////////////////////////////
  a_presence_ans: assert property (s_read(presence_read_cycle_i) |=> bus_data_o == 8'hfe)
    else $error("bad presence answer");
  a_low_group: assert property (s_read(low_group_read_cycle_i && !presence_read_cycle_i)
    |=> bus_data_o == {4'h0, pick($past(universal_inputs_i[7:0]), $past(odd_r))}) else $error("bad low group");
  a_high_group: assert property (s_read(high_group_read_cycle_i && !presence_read_cycle_i
    && !low_group_read_cycle_i) |=> bus_data_o == {4'h0, pick($past(universal_inputs_i[15:8]), $past(odd_r))})
    else $error("bad high group");
  a_load_set: assert property (go && bus_write_cycle_i && bus_data_i[3:1] < 3'h6
    |=> load_sink_outputs_n_o[$past(bus_data_i[3:1])] == !$past(bus_data_i[0])) else $error("bad load write");
  a_loads_hold: assert property (!$stable(load_sink_outputs_n_o) |-> $past(go && bus_write_cycle_i || brst))
    else $error("load changed unasked");
  a_bcast_clear: assert property (brst |=> load_sink_outputs_n_o == 6'h3f && !bus_data_oe_o)
    else $error("broadcast reset missed");
  a_answer_cause: assert property (bus_data_oe_o |-> $past(go && |{presence_read_cycle_i,
    low_group_read_cycle_i, high_group_read_cycle_i})) else $error("answer while unselected");
  a_idle_zero: assert property (!bus_data_oe_o |-> bus_data_o == 8'h00)
    else $error("data without answer");
endmodule // uio_bus_slave_properties
bind universal_io_bus_slave uio_bus_slave_properties #(.BOARD_ID(BOARD_ID)) u_props (.*);

// [uio_master_model.sv]
`timescale 1ns/1ns
module uio_master_model (
  input wire logic clk_i,
  input wire logic [7:0] bus_data_o,
  input wire logic bus_data_oe_o,
  output logic [5:0] ctl_o,
  output logic [11:0] bus_addr_o,
  output logic [3:0] wr_data_o
);
  initial {ctl_o, bus_addr_o, wr_data_o} = '0;
  // One-clock cycle pulse launched and dropped on falling edges; answer taken after
  task automatic cyc(input logic [5:0] k, input logic [11:0] a, input logic [3:0] d, output logic oe, output logic [7:0] q);
    @(negedge clk_i);
    {ctl_o, bus_addr_o, wr_data_o} = {k, a, d};
    @(negedge clk_i);
    {ctl_o, bus_addr_o, wr_data_o} = {6'h00, ~a, ~d}; // Released lines do not hold their value
    oe = bus_data_oe_o;
    q = bus_data_o;
  endtask
endmodule // uio_master_model

// [universal_io_bus_slave_tb_top.sv]
`timescale 1ns/1ns
module universal_io_bus_slave_tb_top;
  localparam logic [11:0] ME = 12'h04b; // Board id 5, jumper open
  localparam logic [5:0] AS = 6'h20, WR = 6'h10, BR = 6'h08, HI = 6'h04, LO = 6'h02, PR = 6'h01;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  logic [15:0] uin = 16'h0000;
  logic [7:0] bdo;
  logic oe;
  logic [5:0] lds;
  logic [5:0] ctl;
  logic [11:0] ad;
  logic [3:0] wd;
  logic o;
  logic [7:0] q;
  int fails = 0;
  int samples_checked = 0;
  always #10 clk_i = ~clk_i;
  uio_master_model m (.clk_i(clk_i), .bus_data_o(bdo), .bus_data_oe_o(oe), .ctl_o(ctl), .bus_addr_o(ad), .wr_data_o(wd));
  universal_io_bus_slave #(.BOARD_ID(4'h5)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .address_jumper_open_i(1'b1), .addr_strobe_i(ctl[5]), .bus_addr_i(ad), .bus_write_cycle_i(ctl[4]),
    .presence_read_cycle_i(ctl[0]), .low_group_read_cycle_i(ctl[1]), .high_group_read_cycle_i(ctl[2]),
    .broadcast_reset_cycle_i(ctl[3]), .bus_data_i(wd), .universal_inputs_i(uin), .bus_data_o(bdo),
    .bus_data_oe_o(oe), .load_sink_outputs_n_o(lds));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Unselected and wrongly addressed boards stay silent
  task automatic t_select;
    m.cyc(BR, 12'h000, 4'h0, o, q);
    m.cyc(PR, 12'h000, 4'h0, o, q);
    chk({7'h00, o}, 8'h00);
    m.cyc(AS, 12'h04a, 4'h0, o, q);
    m.cyc(PR, 12'h000, 4'h0, o, q);
    chk({7'h00, o}, 8'h00);
    m.cyc(AS, ME, 4'h0, o, q);
    m.cyc(PR, 12'h000, 4'h0, o, q);
    chk(q, 8'hfe);
  endtask
  // Each code moves only its own load; code 6 moves none
  task automatic t_loads;
    logic [5:0] e = 6'h3f;
    for (int i = 0; i < 6; i++) begin
      m.cyc(WR, 12'h000, {i[2:0], 1'b1}, o, q);
      e[i] = 1'b0;
      chk({2'h0, lds}, {2'h0, e});
    end
    ce = 1'b0;
    m.cyc(WR, 12'h000, 4'h0, o, q);
    ce = 1'b1;
    chk({2'h0, lds}, {2'h0, e});
    m.cyc(WR, 12'h000, 4'hd, o, q);
    chk({2'h0, lds}, {2'h0, e});
    m.cyc(WR, 12'h000, 4'h6, o, q);
    e[3] = 1'b1;
    chk({2'h0, lds}, {2'h0, e});
  endtask
  // Both halves, repeated reads keep the parity
  task automatic t_groups;
    logic [3:0] e;
    for (int p = 0; p < 2; p++) begin
      uin = p[0] ? 16'h9c35 : 16'h63ca;
      m.cyc(WR, 12'h000, {3'h7, p[0]}, o, q);
      for (int r = 0; r < 4; r++) begin
        for (int k = 0; k < 4; k++) e[k] = uin[8 * r[0] + 2 * k + p];
        m.cyc(r[0] ? HI : LO, 12'h000, 4'h0, o, q);
        chk(q, {4'h0, e});
      end
    end
  endtask
  // Controller side: one channel compared against a stepped threshold source
  task automatic cmp_read(input logic [7:0] lvl, input logic [7:0] thr, input logic [3:0] ch, output logic b);
    uin[ch] = lvl > thr; // Comparator model
    m.cyc(LO, 12'h000, 4'h0, o, q);
    b = q[ch >> 1];
  endtask
  // Hysteresis and successive approximation on channel 2 of logical board 5
  task automatic t_analog;
    logic [7:0] chan_addr;
    logic [7:0] res;
    logic st;
    logic b;
    chan_addr = (8'h05 << 4) + 8'h02;
    res = 8'h00;
    st = 1'b1;
    uin = 16'h0000;
    m.cyc(WR, 12'h000, 4'he, o, q);
    cmp_read(8'h5a, 8'h70, chan_addr[3:0], b);
    if (b) st = 1'b1;
    cmp_read(8'h5a, 8'h40, chan_addr[3:0], b);
    chk({7'h00, b}, 8'h01);
    if (!b) st = 1'b0;
    chk({7'h00, st}, 8'h01);
    for (int i = 7; i >= 0; i--) begin
      cmp_read(8'h5a, (res | (8'h01 << i)) - 8'h01, chan_addr[3:0], b);
      if (b) res = res | (8'h01 << i);
    end
    chk(res, 8'h5a);
  endtask
  task automatic t_breset;
    m.cyc(BR, 12'h000, 4'h0, o, q);
    chk({2'h0, lds}, 8'h3f);
    m.cyc(PR, 12'h000, 4'h0, o, q);
    chk({7'h00, o}, 8'h00);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_select;
    t_loads;
    t_groups;
    t_analog;
    t_breset;
    complete_run;
  end
  // About 38 bus cycles (some 80 clocks) are needed; the margin is generous
  initial begin
    #20000;
    fails++;
    complete_run;
  end
endmodule // universal_io_bus_slave_tb_top
